//--- core/loop_act_params.svh
// Purpose: constants for the loop activation sequencer
// Assumes: 100 MHz reference clock
// Notes: codes shared by command and indication registers
`ifndef LOOP_ACT_PARAMS_SVH
`define LOOP_ACT_PARAMS_SVH
// shared four-bit code table
`define CODE_PUP 4'h0
`define CODE_RES 4'h1
`define CODE_ERR 4'h4
`define CODE_PDN 4'h5
`define CODE_SYNC 4'h6
`define CODE_PEND 4'h8
`define CODE_ACT 4'hc
`define CODE_DEACT 4'hf
// indication register reset value (deactivated)
`define STATUS_RESET 8'h0f
// times in ms and derived cycle counts at 100 MHz
`define CLK_MHZ 100
`define T_LONG_MS 15000
`define T_RESYNC_MS 480
`define T_QUIET_MS 40
`define CYC_PER_MS (`CLK_MHZ * 1000)
// flag validation and teardown counts
`define VALID_COUNT 3
`define TEARDOWN_SF 4
`endif

//--- core/loop_act_pkg.sv
// Purpose: types for the loop activation sequencer
// Assumes: nothing
// Notes: constants live in loop_act_params.svh
package loop_act_pkg;
    // sequencer states, gray in the listed order
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_WAIT_SYNC = 4'h1,
        ST_PENDING = 4'h3,
        ST_BREAK = 4'h2,
        ST_ACTIVE = 4'h6,
        ST_RESYNC = 4'h7,
        ST_TEARDOWN = 4'h5,
        ST_FAIL = 4'h4,
        ST_POWERDOWN = 4'hc
    } seq_state_e;
endpackage : loop_act_pkg

//--- core/loop_activation_sequencer.sv
// Purpose: activation and deactivation sequencer with indication register
// Assumes: line events arrive as one-cycle pulses from the frame logic
// Notes: long counts are parameters so a simulation may shorten them
// Operation
// - indication register low nibble, upper zero
// - serial mode pushes status changes to stack
// - activation entry wins over other interrupts
// - wake tone sets indication, pin when down
// - NT teardown flag zero validated three times
// - LT reports sync indication on superframe lock
// - pending on NT sync or LT wake
// - NT full activation after transparency flag one
// - sync loss errors, retries 480 ms
// - transparency fall while active reports error
// - LT deactivation ends in reset, deactivated report
// - GCI powered-down powerup command is acknowledged
// - cold start first, warm after proper deactivation
// - timers 15 s, 480 ms, 40 ms; long disableable
// - LT proceeds to sync then sends flag one
// - long timeout: error, then deactivated, full reset
// - breakpoint holds LT transmit flag zero
// - LT teardown sends zero flag, waits silence
// - NT sync raises pending, sends ready frames
// - NT completes on flag one validated thrice
// - NT stops on far-end silence, reports deactivation
// - LT sends teardown flag zero four superframes
`include "loop_act_params.svh"
module loop_activation_sequencer import loop_act_pkg::*; #(
    parameter int unsigned LONG_CYC = `T_LONG_MS * `CYC_PER_MS,
    parameter int unsigned RESYNC_CYC = `T_RESYNC_MS * `CYC_PER_MS,
    parameter int unsigned QUIET_CYC = `T_QUIET_MS * `CYC_PER_MS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic nt_mode_i, // 1 = NT end, 0 = LT end
    input wire logic gci_mode_i, // 1 = GCI, 0 = serial control
    input wire logic breakpoint_two_enable_i,
    input wire logic long_timer_disable_i,
    input wire logic cmd_valid_i, // one-cycle command strobe
    input wire logic [3:0] cmd_code_i,
    input wire logic wake_tone_i,
    input wire logic sf_sync_i, // superframe sync level
    input wire logic line_signal_i, // far-end energy present
    input wire logic sf_tick_i, // one pulse per received superframe
    input wire logic rx_act_i, // received transparency flag
    input wire logic rx_dea_i, // received teardown flag
    input wire logic irq_other_i, // lower-priority interrupt request
    input wire logic stack_ready_i, // interrupt stack accepts
    output logic [7:0] activation_status_o,
    output logic stack_push_o,
    output logic [3:0] stack_data_o,
    output logic stack_other_grant_o,
    output logic tx_enable_o,
    output logic tx_act_o,
    output logic tx_dea_o,
    output logic data_open_o,
    output logic powered_o,
    output logic warm_start_o,
    output logic wake_tone_pin_n_o
);
    seq_state_e state_r; // sequencer state
    logic [31:0] timer_r; // phase timer
    logic [31:0] long_r; // 15 s default timer
    logic long_run_r;
    logic [1:0] val_r; // flag validation count
    logic [2:0] sf_cnt_r; // teardown superframe count
    logic act_q_r; // last received transparency flag
    logic [3:0] code_r; // current indication
    logic [3:0] code_nxt;
    logic push_pend_r; // change waiting for stack
    logic warm_r; // warm start allowed
    logic powered_r;
    logic di_due_r; // deactivated due once reset follows fail or teardown
    logic bp_release_r; // completion command seen while pending

    wire cmd_ar = cmd_valid_i && cmd_code_i == `CODE_PEND;
    wire cmd_ac = cmd_valid_i && cmd_code_i == `CODE_ACT;
    wire cmd_pup = cmd_valid_i && cmd_code_i == `CODE_PUP;
    wire cmd_pdn = cmd_valid_i && (cmd_code_i == `CODE_PDN || cmd_code_i == `CODE_DEACT);
    wire cmd_res = cmd_valid_i && cmd_code_i == `CODE_RES;
    wire long_exp = long_run_r && !long_timer_disable_i
                    && long_r >= LONG_CYC - 1;
    wire deact = state_r == ST_RESET || state_r == ST_POWERDOWN;

    // power state follows power commands
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            powered_r <= 1'b0;
        end else if (cmd_pup && !(state_r == ST_ACTIVE && !nt_mode_i)) begin
            powered_r <= 1'b1;
        end else if (cmd_pdn) begin
            powered_r <= 1'b0;
        end
    end

    // main sequencer
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_POWERDOWN;
            timer_r <= 32'h0;
            val_r <= 2'h0;
            sf_cnt_r <= 3'h0;
            bp_release_r <= 1'b0;
        end else begin
            timer_r <= timer_r + 32'h1;
            case (state_r)
                ST_POWERDOWN: begin
                    if (cmd_pup) begin
                        state_r <= ST_RESET;
                    end
                end
                ST_RESET: begin
                    // activation proceeds only after request
                    if (cmd_pdn) begin
                        state_r <= ST_POWERDOWN;
                    end else if (cmd_ar && powered_r) begin
                        state_r <= ST_WAIT_SYNC;
                        bp_release_r <= 1'b0;
                    end
                end
                ST_WAIT_SYNC: begin
                    if (sf_sync_i) begin
                        state_r <= ST_PENDING;
                        val_r <= 2'h0;
                    end
                end
                ST_PENDING: begin
                    if (cmd_ac) begin
                        bp_release_r <= 1'b1;
                    end
                    if (!sf_sync_i) begin
                        state_r <= ST_RESYNC;
                        timer_r <= 32'h0;
                    end else if (!nt_mode_i) begin
                        state_r <= breakpoint_two_enable_i ? ST_BREAK : ST_ACTIVE;
                    end else if (bp_release_r && sf_tick_i) begin
                        // transparency one validated three times
                        if (!rx_act_i) begin
                            val_r <= 2'h0;
                        end else if (val_r == 2'(`VALID_COUNT - 1)) begin
                            state_r <= ST_ACTIVE;
                            val_r <= 2'h0;
                        end else begin
                            val_r <= val_r + 2'h1;
                        end
                    end
                end
                ST_BREAK: begin
                    if (!sf_sync_i) begin
                        state_r <= ST_RESYNC;
                        timer_r <= 32'h0;
                    end else if (cmd_ac) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!sf_sync_i) begin
                        state_r <= ST_RESYNC;
                        timer_r <= 32'h0;
                    end else if (!nt_mode_i && cmd_pup) begin
                        state_r <= ST_TEARDOWN;
                        sf_cnt_r <= 3'h0;
                    end else if (nt_mode_i && sf_tick_i) begin
                        // teardown flag zero validated three times
                        if (rx_dea_i) begin
                            val_r <= 2'h0;
                        end else if (val_r == 2'(`VALID_COUNT - 1)) begin
                            state_r <= ST_TEARDOWN;
                            timer_r <= 32'h0;
                        end else begin
                            val_r <= val_r + 2'h1;
                        end
                    end
                end
                ST_RESYNC: begin
                    if (sf_sync_i && line_signal_i) begin
                        state_r <= ST_PENDING;
                    end else if (!line_signal_i || timer_r >= RESYNC_CYC - 1) begin
                        state_r <= ST_FAIL;
                    end
                end
                ST_TEARDOWN: begin
                    if (!nt_mode_i) begin
                        // four zero flags, then wait for silence
                        if (sf_cnt_r < 3'(`TEARDOWN_SF)) begin
                            sf_cnt_r <= sf_cnt_r + (sf_tick_i ? 3'h1 : 3'h0);
                            timer_r <= 32'h0;
                        end else if (!line_signal_i && timer_r >= QUIET_CYC - 1) begin
                            state_r <= ST_RESET;
                        end else if (line_signal_i) begin
                            timer_r <= 32'h0;
                        end
                    end else if (line_signal_i) begin
                        timer_r <= 32'h0;
                    end else if (timer_r >= QUIET_CYC - 1) begin
                        state_r <= ST_RESET;
                    end
                end
                ST_FAIL: begin
                    state_r <= ST_RESET;
                end
                default: begin
                    state_r <= ST_RESET;
                end
            endcase
            // timeout or reset command forces full reset
            if (long_exp || (cmd_res && !deact)) begin
                state_r <= ST_FAIL;
            end
        end
    end

    // 15 s default timer from request to full activation
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            long_r <= 32'h0;
            long_run_r <= 1'b0;
        end else if (state_r == ST_RESET && cmd_ar && powered_r) begin
            long_r <= 32'h0;
            long_run_r <= 1'b1;
        end else if (state_r == ST_ACTIVE || deact || long_exp) begin
            long_run_r <= 1'b0;
        end else begin
            long_r <= long_r + 32'h1;
        end
    end

    // warm start allowed only after a proper deactivation
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            warm_r <= 1'b0;
        end else if (state_r == ST_FAIL) begin
            warm_r <= 1'b0;
        end else if (state_r == ST_TEARDOWN && (nt_mode_i || sf_cnt_r >= 3'(`TEARDOWN_SF))
                     && !line_signal_i && timer_r >= QUIET_CYC - 1) begin
            warm_r <= 1'b1;
        end
    end

    // received transparency history for fall detection
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            act_q_r <= 1'b0;
        end else if (sf_tick_i) begin
            act_q_r <= rx_act_i;
        end
    end

    // next indication code; only table codes appear
    always_comb begin
        code_nxt = code_r;
        if (state_r == ST_FAIL) begin
            code_nxt = `CODE_ERR;
        end else if (di_due_r && state_r == ST_RESET) begin
            // keyed on the entry into reset, since code 0 is shared by
            // pending deactivation and power-up acknowledge
            code_nxt = `CODE_DEACT;
        end else if (deact && wake_tone_i) begin
            code_nxt = nt_mode_i ? `CODE_PUP : `CODE_PEND;
        end else if (state_r == ST_POWERDOWN && cmd_pup && gci_mode_i) begin
            code_nxt = `CODE_PUP;
        end else if (state_r == ST_TEARDOWN && nt_mode_i && code_r == `CODE_ACT) begin
            code_nxt = `CODE_PUP; // pending deactivation
        end else if (state_r == ST_RESYNC) begin
            code_nxt = `CODE_ERR;
        end else if (state_r == ST_ACTIVE && act_q_r && sf_tick_i && !rx_act_i) begin
            code_nxt = `CODE_ERR;
        end else if (state_r == ST_ACTIVE && code_r != `CODE_ERR) begin
            code_nxt = `CODE_ACT;
        end else if (state_r == ST_BREAK) begin
            code_nxt = `CODE_ACT; // host must answer with completion
        end else if (state_r == ST_PENDING) begin
            code_nxt = nt_mode_i ? `CODE_PEND : `CODE_SYNC;
        end
    end

    // indication register holds last code
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            code_r <= 4'(`STATUS_RESET);
            di_due_r <= 1'b0;
        end else begin
            code_r <= code_nxt;
            // teardown and fail only ever leave towards reset or fail
            di_due_r <= state_r == ST_FAIL || state_r == ST_TEARDOWN;
        end
    end

    // push queue to stack in serial mode only
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            push_pend_r <= 1'b0;
        end else if (code_nxt != code_r && !gci_mode_i) begin
            push_pend_r <= 1'b1;
        end else if (stack_ready_i) begin
            push_pend_r <= 1'b0;
        end
    end

    assign activation_status_o = {4'h0, code_r};
    assign stack_push_o = push_pend_r;
    assign stack_data_o = code_r;
    assign stack_other_grant_o = irq_other_i && !push_pend_r && stack_ready_i;
    assign tx_enable_o = !deact && state_r != ST_FAIL;
    assign tx_act_o = state_r == ST_ACTIVE;
    assign tx_dea_o = state_r != ST_TEARDOWN;
    assign data_open_o = state_r == ST_ACTIVE && code_r == `CODE_ACT;
    assign powered_o = powered_r;
    assign warm_start_o = warm_r;
    assign wake_tone_pin_n_o = !(state_r == ST_POWERDOWN && wake_tone_i);

    // assertions
    a_upper_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        activation_status_o[7:4] == 4'h0) else $error("upper status bits set");
    a_push_serial: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (code_nxt != code_r && !gci_mode_i) |=> stack_push_o) else $error("no push");
    a_push_priority: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        stack_push_o |-> !stack_other_grant_o) else $error("priority lost");
    a_wake_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_POWERDOWN && wake_tone_i) |-> !wake_tone_pin_n_o)
        else $error("wake pin not low");
    a_fail_then_di: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == ST_FAIL |=> code_r == `CODE_ERR ##1 code_r == `CODE_DEACT)
        else $error("error then deactivated missing");
    a_break_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        state_r == ST_BREAK |-> !tx_act_o) else $error("flag not held");
    a_teardown_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(state_r == ST_TEARDOWN) && !nt_mode_i |-> !tx_dea_o [*4])
        else $error("teardown too short");
    a_nt_pending: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (state_r == ST_PENDING && nt_mode_i && !long_exp && !cmd_res) |=> code_r == `CODE_PEND)
        else $error("pending missing");
    a_open_active: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        data_open_o |-> state_r == ST_ACTIVE) else $error("data open early");
    c_full_act: cover property (@(posedge ref_clk_i) code_r == `CODE_ACT);
    c_timeout: cover property (@(posedge ref_clk_i) long_exp);
    c_teardown: cover property (@(posedge ref_clk_i)
        state_r == ST_TEARDOWN ##1 state_r == ST_RESET);
endmodule : loop_activation_sequencer

//--- sim/far_end_model.sv
// Purpose: remote transceiver seen across the line
// Assumes: device transmit enable means the far end hears us
// Notes: flags are valid only on a tick, inverted between ticks
module far_end_model (
    input wire logic ref_clk_i,
    input wire logic tx_enable_i,
    input wire logic tx_dea_i,
    input wire logic sync_on_i, // bench lets sync form
    input wire logic act_val_i, // transparency flag sent
    input wire logic dea_val_i, // teardown flag sent
    input wire logic cut_i, // bench silences the far end
    output logic sf_sync_o,
    output logic line_signal_o,
    output logic sf_tick_o,
    output logic rx_act_o,
    output logic rx_dea_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] phase_r = 3'h0; // superframe phase
    logic [2:0] zero_cnt_r = 3'h0; // zero teardown flags seen
    logic ceased_r = 1'b0; // far end stopped sending
    // energy only while we are heard and not stopped
    assign line_signal_o = tx_enable_i & ~cut_i & ~ceased_r;
    assign sf_sync_o = line_signal_o & sync_on_i;
    assign sf_tick_o = line_signal_o & (phase_r == 3'h7);
    // stale flag lines invert so a stray sample is caught
    assign rx_act_o = sf_tick_o ? act_val_i : ~act_val_i;
    assign rx_dea_o = sf_tick_o ? dea_val_i : ~dea_val_i;
    // one superframe every eight cycles
    always_ff @(posedge ref_clk_i) begin
        phase_r <= line_signal_o ? phase_r + 3'h1 : 3'h0;
    end
    // stop after four zero teardown flags
    always_ff @(posedge ref_clk_i) begin
        if (!tx_enable_i) begin
            zero_cnt_r <= 3'h0;
            ceased_r <= 1'b0;
        end else if (sf_tick_o && !tx_dea_i) begin
            zero_cnt_r <= zero_cnt_r + 3'h1;
            if (zero_cnt_r == 3'h3) ceased_r <= 1'b1;
        end
    end
endmodule : far_end_model

//--- sim/tb_loop_activation_sequencer.sv
// Purpose: self-checking bench for the loop activation sequencer
// Assumes: shortened timers, LT runs then NT runs
// Notes: status changes are matched in order against queued notes
`include "loop_act_params.svh"
module tb_loop_activation_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned LONG_C = 200, RESYNC_C = 50, QUIET_C = 10;
    logic ref_clk = 1'b0, rst_n = 1'b0, nt_mode = 1'b0, gci_mode = 1'b1;
    logic bp_en = 1'b0, ltd = 1'b0, cmd_valid = 1'b0, wake_tone = 1'b0;
    logic irq_other = 1'b0, stack_ready = 1'b1, sync_on = 1'b0;
    logic act_val = 1'b0, dea_val = 1'b1, cut = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic sf_sync, line_sig, sf_tick, rx_act, rx_dea; // far end
    logic push, grant, tx_en, tx_act, tx_dea, data_open, powered, warm, pin_n;
    logic [7:0] status, last_st;
    logic [3:0] sdata;
    logic [31:0] rnd;
    logic [7:0] exp_q[$]; // expected status changes
    integer seed = 32'h4983;
    int tests_run = 0, miscompares = 0;
    // free-running clock, 100 MHz
    always #5 ref_clk = ~ref_clk;
    loop_activation_sequencer #(.LONG_CYC(LONG_C), .RESYNC_CYC(RESYNC_C),
        .QUIET_CYC(QUIET_C)) i_dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .nt_mode_i(nt_mode), .gci_mode_i(gci_mode),
        .breakpoint_two_enable_i(bp_en), .long_timer_disable_i(ltd),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .wake_tone_i(wake_tone),
        .sf_sync_i(sf_sync), .line_signal_i(line_sig), .sf_tick_i(sf_tick),
        .rx_act_i(rx_act), .rx_dea_i(rx_dea), .irq_other_i(irq_other),
        .stack_ready_i(stack_ready), .activation_status_o(status),
        .stack_push_o(push), .stack_data_o(sdata), .stack_other_grant_o(grant),
        .tx_enable_o(tx_en), .tx_act_o(tx_act), .tx_dea_o(tx_dea),
        .data_open_o(data_open), .powered_o(powered), .warm_start_o(warm),
        .wake_tone_pin_n_o(pin_n));
    far_end_model i_far (.ref_clk_i(ref_clk), .tx_enable_i(tx_en),
        .tx_dea_i(tx_dea), .sync_on_i(sync_on), .act_val_i(act_val),
        .dea_val_i(dea_val), .cut_i(cut), .sf_sync_o(sf_sync),
        .line_signal_o(line_sig), .sf_tick_o(sf_tick), .rx_act_o(rx_act),
        .rx_dea_o(rx_dea));
    // random stack stalls and competing requests
    always @(posedge ref_clk) begin
        rnd = $random(seed);
        irq_other <= rnd[0];
        stack_ready <= |rnd[2:1];
    end
    task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_code
    task automatic check_bit(input logic got, input logic exp);
        check_code({7'h0, got}, {7'h0, exp});
    endtask : check_bit
    // watcher: every status change must match the oldest note
    always @(posedge ref_clk) begin
        if (rst_n && status !== last_st) begin
            if (exp_q.size() == 0) check_code(status, 8'hee);
            else check_code(status, exp_q.pop_front());
        end
        if (rst_n && push && stack_ready) check_code({4'h0, sdata}, status);
        if (rst_n) check_bit(grant, irq_other & ~push & stack_ready);
        if (rst_n && gci_mode) check_bit(push, 1'b0);
        last_st <= status;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    task automatic note(input logic [3:0] c);
        exp_q.push_back({4'h0, c});
    endtask : note
    task automatic cmd(input logic [3:0] c);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
    endtask : cmd
    // bounded wait until at most left notes remain
    task automatic wait_left(input int n, input int left);
        int k;
        k = 0;
        while (exp_q.size() > left && k < n) begin
            @(posedge ref_clk);
            k++;
        end
        #1;
        check_bit(exp_q.size() <= left, 1'b1);
    endtask : wait_left
    // lt activation up to full active
    task automatic lt_up();
        note(`CODE_SYNC);
        note(`CODE_ACT);
        cmd(`CODE_PEND);
        wait_left(100, 0);
    endtask : lt_up
    // lt teardown: zero flags for four superframes, then silence
    task automatic lt_down();
        note(`CODE_DEACT);
        cmd(`CODE_PUP);
        cyc(20);
        check_bit(tx_dea, 1'b0);
        check_bit(exp_q.size() == 1, 1'b1);
        wait_left(400, 0);
    endtask : lt_down
    task automatic conclude();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    // watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        conclude();
    end
    initial begin
        cyc(8);
        @(posedge ref_clk) rst_n <= 1'b1;
        cyc(1);
        check_code(status, `STATUS_RESET);
        // request before power-up is ignored
        cmd(`CODE_PEND);
        cyc(5);
        check_bit(tx_en, 1'b0);
        note(`CODE_PUP);
        cmd(`CODE_PUP);
        wait_left(20, 0);
        check_bit(powered, 1'b1);
        @(posedge ref_clk) gci_mode <= 1'b0;
        @(posedge ref_clk) sync_on <= 1'b1;
        lt_up();
        check_bit(tx_act, 1'b1);
        check_bit(data_open, 1'b1);
        check_bit(warm, 1'b0);
        // sync lost while the line stays lit
        @(posedge ref_clk) sync_on <= 1'b0;
        note(`CODE_ERR);
        note(`CODE_DEACT);
        wait_left(50, 1);
        check_bit(data_open, 1'b0);
        wait_left(300, 0);
        @(posedge ref_clk) sync_on <= 1'b1;
        lt_up();
        lt_down();
        // breakpoint holds transmit flag until completion
        @(posedge ref_clk) bp_en <= 1'b1;
        lt_up();
        check_bit(warm, 1'b1);
        check_bit(tx_act, 1'b0);
        cmd(`CODE_ACT);
        cyc(2);
        check_bit(tx_act, 1'b1);
        check_bit(data_open, 1'b1);
        // far-end transparency falls while active
        note(`CODE_ERR);
        @(posedge ref_clk) act_val <= 1'b1;
        cyc(9);
        @(posedge ref_clk) act_val <= 1'b0;
        wait_left(20, 0);
        check_bit(data_open, 1'b0);
        lt_down();
        // long timer: held off while disabled, then expires
        @(posedge ref_clk) bp_en <= 1'b0;
        sync_on <= 1'b0;
        ltd <= 1'b1;
        cmd(`CODE_PEND);
        cyc(300);
        check_bit(tx_en, 1'b1);
        @(posedge ref_clk) ltd <= 1'b0;
        note(`CODE_ERR);
        note(`CODE_DEACT);
        wait_left(600, 0);
        // nt end: pending, completion, teardown from far end
        @(posedge ref_clk) nt_mode <= 1'b1;
        sync_on <= 1'b1;
        note(`CODE_PEND);
        cmd(`CODE_PEND);
        wait_left(100, 0);
        check_bit(tx_act, 1'b0);
        note(`CODE_ACT);
        cmd(`CODE_ACT);
        @(posedge ref_clk) act_val <= 1'b1;
        cyc(14);
        check_bit(exp_q.size() == 1, 1'b1);
        wait_left(100, 0);
        note(`CODE_PUP);
        @(posedge ref_clk) dea_val <= 1'b0;
        cyc(14);
        check_bit(exp_q.size() == 1, 1'b1);
        wait_left(100, 0);
        note(`CODE_DEACT);
        @(posedge ref_clk) cut <= 1'b1;
        wait_left(100, 0);
        check_bit(tx_en, 1'b0);
        @(posedge ref_clk) cut <= 1'b0;
        sync_on <= 1'b0;
        // powered down, wake tone pulls the pin
        cmd(`CODE_PDN);
        cyc(3);
        check_bit(powered, 1'b0);
        note(`CODE_PUP);
        @(posedge ref_clk) wake_tone <= 1'b1;
        wait_left(20, 0);
        check_bit(pin_n, 1'b0);
        conclude();
    end
endmodule : tb_loop_activation_sequencer
